// ==== mbt_baud_div.sv ====
// Purpose: Five-bit divide-by-k counter and the halving stage that makes the baud clock.
// Assumes: tick is one aclk cycle wide.
// Notes: phase is the baud clock; one baud period is 2k base ticks.
module mbt_baud_div #(
  parameter int CW = mbt_pkg::BRS_W
) (
  input logic aclk,
  input logic aresetn,
  input logic tick,
  input logic clear,
  input logic [CW-1:0] kval,
  output logic term,
  output logic phase
);
  import mbt_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic phase;
  } mbt_div_t;

  mbt_div_t s_reg;
  mbt_div_t s_next;
  logic [CW-1:0] k_eff;

  // Divisor codes below eight are forced to four.
  always_comb begin
    s_next = s_reg;
    k_eff = (kval < CW'(K_LOW_LIMIT)) ? CW'(K_MIN) : kval;
    term = (s_reg.cnt == k_eff - CW'(1));
    if (clear) begin
      s_next = '0;
    end else if (tick && term) begin
      s_next.cnt = '0;
      s_next.phase = ~s_reg.phase;
    end else if (tick) begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign phase = s_reg.phase;

  a_half_baud: assert property (@(posedge aclk) disable iff (!aresetn)
    (!clear && !(tick && term)) |=> $stable(phase)) else $error("Baud clock moved early.");
  a_k_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    (kval < CW'(K_LOW_LIMIT) && s_reg.cnt == CW'(3)) |-> term) else $error("Divisor floor lost.");
endmodule

// ==== mbt_pkg.sv ====
// Purpose: Shared constants and types of the coded serial transmitter.
// Assumes: Registers are byte wide and sit in the low byte of a 32-bit bus word.
// Notes: Byte address of every register is four times its index.
package mbt_pkg;
  typedef logic [31:0] mbt_addr_t;
  typedef logic [7:0] mbt_byte_t;

  // Register indices; the bus address is the index shifted up by two.
  localparam logic [29:0] IDX_CTL0 = 30'h0000FF4C;
  localparam logic [29:0] IDX_CTL1 = 30'h0000FF4D;
  localparam logic [29:0] IDX_CTL2 = 30'h0000FF4E;
  localparam logic [29:0] IDX_BITCNT = 30'h0000FF4F;
  localparam logic [29:0] IDX_TXBUF = 30'h0000FF50;
  localparam logic [29:0] IDX_STATUS = 30'h0000FF51;
  localparam mbt_addr_t ADDR_CTL0 = {IDX_CTL0, 2'h0};
  localparam mbt_addr_t ADDR_CTL1 = {IDX_CTL1, 2'h0};
  localparam mbt_addr_t ADDR_CTL2 = {IDX_CTL2, 2'h0};
  localparam mbt_addr_t ADDR_BITCNT = {IDX_BITCNT, 2'h0};
  localparam mbt_addr_t ADDR_TXBUF = {IDX_TXBUF, 2'h0};
  localparam mbt_addr_t ADDR_STATUS = {IDX_STATUS, 2'h0};

  // Field positions, writable masks and reset values.
  localparam int CTL0_EN = 7;
  localparam int CTL0_DIR = 4;
  localparam int CTL0_OSL = 1;
  localparam int CTL0_OLV = 0;
  localparam mbt_byte_t CTL0_MASK = 8'h93;
  localparam mbt_byte_t CTL1_MASK = 8'h07;
  localparam mbt_byte_t CTL2_MASK = 8'h1F;
  localparam mbt_byte_t BITCNT_MASK = 8'h07;
  localparam mbt_byte_t CTL0_RST = 8'h10;
  localparam mbt_byte_t CTL1_RST = 8'h00;
  localparam mbt_byte_t CTL2_RST = 8'h1F;

  // Baud divider and clock select limits.
  localparam int BRS_W = 5;
  localparam int SEL_W = 3;
  localparam logic [4:0] K_MIN = 5'h04;
  localparam logic [4:0] K_LOW_LIMIT = 5'h08;
  localparam logic [2:0] SEL_MAX = 3'h5;
  localparam logic [1:0] GAP_TICKS = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} mbt_state_t;

  // Whole state of the top module.
  typedef struct packed {
    mbt_state_t st;
    mbt_byte_t ctl0;
    mbt_byte_t ctl1;
    mbt_byte_t ctl2;
    mbt_byte_t bitcnt;
    mbt_byte_t txbuf;
    mbt_byte_t shreg;
    logic [2:0] cnt;
    logic pend;
    logic pend_late;
    logic [1:0] gap;
    logic pin;
    logic irq;
    mbt_addr_t awaddr;
    logic aw_have;
    logic w_have;
    mbt_byte_t wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    mbt_byte_t rdata;
  } mbt_regs_t;

  localparam mbt_regs_t REGS_RST = '{st: ST_IDLE, ctl0: CTL0_RST, ctl1: CTL1_RST,
                                     ctl2: CTL2_RST, default: '0};
endpackage

// ==== mbt_prescaler.sv ====
// Purpose: Base clock tick generator, aclk divided by a power of two.
// Assumes: The select code is stable while run is high.
// Notes: Codes above the largest legal one behave as the largest divider.
module mbt_prescaler #(
  parameter int SEL_W = mbt_pkg::SEL_W,
  parameter int CNT_W = 5
) (
  input logic aclk,
  input logic aresetn,
  input logic run,
  input logic [SEL_W-1:0] sel,
  output logic tick
);
  import mbt_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } mbt_pre_t;

  mbt_pre_t s_reg;
  mbt_pre_t s_next;
  logic [SEL_W-1:0] sel_eff;
  logic [CNT_W-1:0] mask;

  // Tick whenever the selected low bits are all ones; code 0 ticks every cycle.
  always_comb begin
    s_next = s_reg;
    sel_eff = (sel > SEL_W'(SEL_MAX)) ? SEL_W'(SEL_MAX) : sel;
    mask = CNT_W'((1 << sel_eff) - 1);
    tick = run && ((s_reg.cnt | ~mask) == '1);
    s_next.cnt = run ? s_reg.cnt + CNT_W'(1) : '0;
  end

  // The counter restarts while stopped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  a_div_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && sel == '0) |-> tick) else $error("Undivided base clock missed a tick.");
endmodule

// ==== mbt_rx_model.sv ====
// Purpose: Remote receiver on the coded serial line, decoding one frame per buffer load.
// Assumes: The bench tells it the half-bit length in aclk cycles, the coding and the bit count.
// Notes: It restarts at every load pulse and samples each half bit in its middle.
module mbt_rx_model (
  input logic aclk,
  input logic pin,
  input logic irq,
  input logic manch,
  input logic [9:0] half,
  input logic [3:0] want,
  output logic [7:0] bits,
  output logic [3:0] nbits,
  output logic bad
);
  timeunit 1ns;
  timeprecision 1ps;
  int t = 0;
  int h;
  int hh;
  logic first = 1'b0;

  // Mid-point sampling tolerates the prescaler phase, which may shorten the first half.
  always_comb begin
    h = int'(half);
    hh = h / 2;
  end

  // Even halves carry the data; odd halves must be its inverse when coded.
  always @(posedge aclk) begin
    if (irq === 1'b1) begin
      t <= 0;
      nbits <= 4'h0;
      bits <= 8'h00;
      bad <= 1'b0;
    end else begin
      t <= t + 1;
      if (nbits < want && t >= hh && (t - hh) % h == 0) begin
        if (((t - hh) / h) % 2 == 0) begin
          first <= pin;
          if (!manch) begin
            bits[nbits[2:0]] <= pin;
            nbits <= nbits + 4'h1;
          end
        end else if (manch) begin
          bad <= bad | (pin !== ~first);
          bits[nbits[2:0]] <= first;
          nbits <= nbits + 4'h1;
        end
      end
    end
  end
endmodule

// ==== mbt_top.sv ====
// Purpose: Coded serial transmitter, Manchester or plain bits, with an AXI4-Lite slave.
// Assumes: Software keeps enable low while changing mode, clock or divisor fields.
// Notes: The output pin lags the internal bit state by one aclk cycle.
module mbt_top (
  input logic aclk,
  input logic aresetn,
  input mbt_pkg::mbt_addr_t awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input mbt_pkg::mbt_addr_t araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  output logic coded_output_pin,
  output logic buffer_load_interrupt
);
  import mbt_pkg::*;

  mbt_regs_t s_reg;
  mbt_regs_t s_next;
  logic base_tick;
  logic term;
  logic phase;
  logic div_clear;
  logic last_done;
  logic late;
  logic load_buf;
  logic start_now;
  logic wr_go;
  logic tx_wr;
  logic bit_val;

  // Base clock; it only runs while the block is enabled.
  mbt_prescaler #(
    .SEL_W(SEL_W),
    .CNT_W(5)
  ) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_reg.ctl0[CTL0_EN]),
    .sel(s_reg.ctl1[SEL_W-1:0]),
    .tick(base_tick)
  );

  // Baud generator, held cleared outside a bit stream.
  mbt_baud_div #(
    .CW(BRS_W)
  ) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(base_tick),
    .clear(div_clear),
    .kval(s_reg.ctl2[BRS_W-1:0]),
    .term(term),
    .phase(phase)
  );

  // Next state: transmitter first, then bus writes, then bus reads.
  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    load_buf = 1'b0;
    start_now = 1'b0;
    wr_go = 1'b0;
    tx_wr = 1'b0;
    bit_val = 1'b0;
    last_done = base_tick && term && phase;
    // Late window covers the second half of the last bit plus one base clock.
    late = (s_reg.st == ST_SEND) && (s_reg.cnt == 3'h0) && (phase || term);

    case (s_reg.st)
      ST_IDLE: begin
        s_next.st = ST_IDLE;
      end
      ST_SEND: begin
        if (last_done) begin
          if (s_reg.cnt != 3'h0) begin
            s_next.cnt = s_reg.cnt - 3'h1;
            if (s_reg.ctl0[CTL0_DIR]) begin
              s_next.shreg = {1'b0, s_reg.shreg[7:1]};
            end
          end else if (s_reg.pend && !s_reg.pend_late) begin
            load_buf = 1'b1;
          end else if (s_reg.pend) begin
            s_next.st = ST_GAP;
            s_next.gap = 2'h0;
          end else begin
            s_next.st = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (base_tick) begin
          if (s_reg.gap == GAP_TICKS - 2'h1) begin
            load_buf = 1'b1;
          end else begin
            s_next.gap = s_reg.gap + 2'h1;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // A queued byte moves into the shift register with its own bit count.
    if (load_buf) begin
      s_next.st = ST_SEND;
      s_next.shreg = s_reg.txbuf;
      s_next.cnt = s_reg.bitcnt[2:0];
      s_next.pend = 1'b0;
      s_next.pend_late = 1'b0;
      s_next.irq = 1'b1;
    end

    // Write address and data are taken independently, in either order.
    if (bready && s_reg.bvalid) begin
      s_next.bvalid = 1'b0;
    end
    if (awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.wdata = wdata[7:0];
      s_next.wstrb0 = wstrb[0];
    end
    wr_go = s_next.aw_have && s_next.w_have && !s_reg.bvalid;

    // Only byte lane 0 carries register bits; other lanes are ignored.
    if (wr_go) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case (s_next.awaddr)
        ADDR_CTL0: begin
          if (s_next.wstrb0) begin
            s_next.ctl0 = s_next.wdata & CTL0_MASK;
          end
        end
        ADDR_CTL1: begin
          if (s_next.wstrb0) begin
            s_next.ctl1 = s_next.wdata & CTL1_MASK;
          end
        end
        ADDR_CTL2: begin
          if (s_next.wstrb0) begin
            s_next.ctl2 = s_next.wdata & CTL2_MASK;
          end
        end
        ADDR_BITCNT: begin
          if (s_next.wstrb0) begin
            s_next.bitcnt = s_next.wdata & BITCNT_MASK;
          end
        end
        ADDR_TXBUF: begin
          if (s_next.wstrb0) begin
            s_next.txbuf = s_next.wdata;
            tx_wr = 1'b1;
          end
        end
        ADDR_STATUS: begin
          s_next.bresp = RESP_OKAY;
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // A buffer write with enable set starts at once when idle, otherwise it is queued.
    if (tx_wr && s_next.ctl0[CTL0_EN]) begin
      if (s_next.st == ST_IDLE) begin
        start_now = 1'b1;
        s_next.st = ST_SEND;
        s_next.shreg = s_next.wdata;
        s_next.cnt = s_next.bitcnt[2:0];
        s_next.irq = 1'b1;
      end else begin
        s_next.pend = 1'b1;
        s_next.pend_late = late && !load_buf;
      end
    end

    // Clearing enable abandons the transfer and any queued byte.
    if (!s_next.ctl0[CTL0_EN]) begin
      s_next.st = ST_IDLE;
      s_next.pend = 1'b0;
      s_next.pend_late = 1'b0;
    end

    // Read data are sampled at the address handshake.
    if (rready && s_reg.rvalid) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      case (araddr)
        ADDR_CTL0: s_next.rdata = s_reg.ctl0;
        ADDR_CTL1: s_next.rdata = s_reg.ctl1;
        ADDR_CTL2: s_next.rdata = s_reg.ctl2;
        ADDR_BITCNT: s_next.rdata = s_reg.bitcnt;
        ADDR_TXBUF: s_next.rdata = s_reg.txbuf;
        ADDR_STATUS: begin
          s_next.rdata = {1'b0, s_reg.cnt, 1'b0, s_reg.pend_late, s_reg.pend,
                          (s_reg.st != ST_IDLE)};
        end
        default: begin
          s_next.rdata = 8'h00;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready = !s_next.w_have && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;

    // Pin level: idle level outside a stream, else raw or Manchester bit.
    bit_val = s_reg.ctl0[CTL0_DIR] ? s_reg.shreg[0] : s_reg.shreg[s_reg.cnt];
    if (s_reg.st != ST_SEND) begin
      s_next.pin = s_reg.ctl0[CTL0_OLV];
    end else if (s_reg.ctl0[CTL0_OSL]) begin
      s_next.pin = bit_val;
    end else begin
      s_next.pin = bit_val ^ phase;
    end

    // Restart the baud phase at every load so each byte starts on a whole bit.
    div_clear = (s_next.st != ST_SEND) || load_buf || start_now;
  end

  // Single state register; reset values of the control registers live in REGS_RST.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= REGS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rresp = s_reg.rresp;
  assign rdata = {24'h000000, s_reg.rdata};
  assign coded_output_pin = s_reg.pin;
  assign buffer_load_interrupt = s_reg.irq;

  a_ctl0_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> (s_reg.ctl0 == CTL0_RST && s_reg.ctl2 == CTL2_RST))
    else $error("Control registers left reset wrong.");
  a_irq_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (load_buf || start_now)
    |=> ((buffer_load_interrupt && s_reg.st == ST_SEND) || !s_reg.ctl0[CTL0_EN]))
    else $error("Load without interrupt.");
  a_idle_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st != ST_SEND) |=> (coded_output_pin == $past(s_reg.ctl0[CTL0_OLV])))
    else $error("Idle pin level wrong.");
  a_seq_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_SEND && s_reg.ctl0[CTL0_OSL]) |=> (coded_output_pin == $past(bit_val)))
    else $error("Plain bit output wrong.");
  a_manch_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_SEND && !s_reg.ctl0[CTL0_OSL])
    |=> (coded_output_pin == ($past(bit_val) ^ $past(phase))))
    else $error("Manchester output wrong.");
  a_late_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_SEND && last_done && s_reg.cnt == 3'h0 && s_reg.pend_late)
    |=> (s_reg.st == ST_GAP || !s_reg.ctl0[CTL0_EN]))
    else $error("Late byte skipped the gap.");
  a_gap_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_GAP && !base_tick) |=> (s_reg.st != ST_SEND))
    else $error("Gap ended without a base tick.");
  a_last_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_SEND && last_done && s_reg.cnt != 3'h0)
    |=> ((s_reg.st == ST_SEND && s_reg.cnt == $past(s_reg.cnt) - 3'h1)
         || !s_reg.ctl0[CTL0_EN]))
    else $error("Transfer ended before count zero.");
  a_disable_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_reg.ctl0[CTL0_EN] |-> (s_reg.st == ST_IDLE && !s_reg.pend))
    else $error("Transmitter active while stopped.");
endmodule

// ==== mbt_top_tb_top.sv ====
// Purpose: Self-checking bench of the coded serial transmitter and its register slave.
// Assumes: Clock select and divisor stay small enough that every frame ends quickly.
// Notes: Bus signals change only by non-blocking assignment right after a rising edge.
module mbt_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mbt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  mbt_addr_t awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, irq, bad, manch = 1'b0;
  logic [1:0] bresp, rresp;
  logic [9:0] half = 10'h004;
  logic [3:0] want = 4'h1, nbits;
  logic [7:0] bits;
  int err_total = 0, comparisons = 0, cyc = 0, irq_n = 0, irq_t = 0;

  mbt_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .coded_output_pin(pin), .buffer_load_interrupt(irq));
  mbt_rx_model rx_u (.aclk(aclk), .pin(pin), .irq(irq), .manch(manch), .half(half),
    .want(want), .bits(bits), .nbits(nbits), .bad(bad));

  // A 40 MHz clock.
  initial forever #12.5 aclk = ~aclk;

  // Load pulses are time-stamped; the cycle ceiling cuts a hang short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      irq_n <= irq_n + 1;
      irq_t <= cyc;
    end
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data are offered together; each is released once taken.
  // bready and rready stay high between transfers so no strobe is driven twice in a step.
  task automatic axi_wr(input mbt_addr_t a, input mbt_byte_t d, output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd_chk(input mbt_addr_t a, input logic [31:0] e, input logic [1:0] er,
                        input string nm);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(nm, e, rdata);
    chk(nm, 32'(er), 32'(rresp));
  endtask

  // Mode fields change only with the enable low, then the enable is set alone.
  task automatic setup(input mbt_byte_t c0, input mbt_byte_t c1, input mbt_byte_t c2,
                       input mbt_byte_t bc);
    logic [1:0] r;
    half = 10'(((c2 < 8'h08) ? 4 : int'(c2[4:0])) << c1[2:0]);
    manch = ~c0[1];
    want = {1'b0, bc[2:0]} + 4'h1;
    axi_wr(ADDR_CTL0, c0 & 8'h7F, r);
    axi_wr(ADDR_CTL1, c1, r);
    axi_wr(ADDR_CTL2, c2, r);
    axi_wr(ADDR_BITCNT, bc, r);
    axi_wr(ADDR_CTL0, c0, r);
  endtask

  task automatic run_frame(input mbt_byte_t c0, input mbt_byte_t c1, input mbt_byte_t c2,
                           input mbt_byte_t d, input mbt_byte_t bc);
    logic [1:0] r;
    logic [7:0] ex;
    int n0;
    ex = 8'h00;
    setup(c0, c1, c2, bc);
    for (int i = 0; i <= int'(bc[2:0]); i++) ex[i] = c0[4] ? d[i] : d[int'(bc[2:0]) - i];
    n0 = irq_n;
    axi_wr(ADDR_TXBUF, d, r);
    while (irq_n == n0 || nbits !== want) @(posedge aclk);
    chk("rx_bits", 32'(ex), 32'(bits));
    chk("rx_coding", 32'h0, 32'(bad));
    repeat (2 * int'(half)) @(posedge aclk);
    chk("pin_idle", 32'(c0[0]), 32'(pin));
    rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY, "status_done");
  endtask

  task automatic t_reset();
    logic [1:0] r;
    int n0;
    chk("pin_reset", 32'h0, 32'(pin));
    rd_chk(ADDR_CTL0, 32'h10, RESP_OKAY, "ctl0_reset");
    rd_chk(ADDR_CTL1, 32'h0, RESP_OKAY, "ctl1_reset");
    rd_chk(ADDR_CTL2, 32'h1F, RESP_OKAY, "ctl2_reset");
    rd_chk(ADDR_STATUS + 32'h4, 32'h0, RESP_SLVERR, "unmapped_rd");
    axi_wr(ADDR_STATUS + 32'h4, 8'h55, r);
    chk("unmapped_wr", 32'(RESP_SLVERR), 32'(r));
    axi_wr(ADDR_CTL0, 8'h7F, r);
    rd_chk(ADDR_CTL0, 32'h13, RESP_OKAY, "ctl0_mask");
    chk("pin_idle_high", 32'h1, 32'(pin));
    axi_wr(ADDR_CTL0, 8'h10, r);
    n0 = irq_n;
    axi_wr(ADDR_TXBUF, 8'hA5, r);
    repeat (40) @(posedge aclk);
    chk("no_start_disabled", 32'(n0), 32'(irq_n));
  endtask

  // Every direction, format and idle level, with a full byte.
  task automatic t_modes();
    for (int i = 0; i < 8; i++)
      run_frame({3'b100, i[2], 2'b00, i[1:0]}, 8'h00, 8'h03, 8'hB4, 8'h07);
  endtask

  // Every bit count, alternating the first bit each frame and the idle level every two frames.
  task automatic t_counts();
    for (int b = 0; b < 8; b++)
      run_frame({3'b100, b[0], 3'b000, b[1]}, 8'h00, 8'h05, 8'hC6, 8'(b));
  endtask

  // Each legal clock select, with divisor codes below and above eight.
  task automatic t_clock();
    mbt_byte_t kt [6] = '{8'h02, 8'h09, 8'h1F, 8'h04, 8'h07, 8'h08};
    for (int i = 0; i < 6; i++)
      run_frame(i[0] ? 8'h92 : 8'h80, 8'(i), kt[i], 8'h96, 8'h07);
  endtask

  // A second load early gives a seamless frame; a late one adds two base clocks.
  task automatic t_back(input int w, input int gap);
    logic [1:0] r;
    int n0;
    int p;
    setup(8'h91, 8'h00, 8'h08, 8'h01);
    n0 = irq_n;
    axi_wr(ADDR_TXBUF, 8'h02, r);
    while (irq_n == n0) @(posedge aclk);
    p = irq_t;
    repeat (w) @(posedge aclk);
    want = 4'h3;
    axi_wr(ADDR_BITCNT, 8'h02, r);
    axi_wr(ADDR_TXBUF, 8'h05, r);
    while (irq_n != n0 + 2) @(posedge aclk);
    chk("load_spacing", 32'(gap), 32'(irq_t - p));
    while (nbits !== want) @(posedge aclk);
    chk("rx_next", 32'h5, 32'(bits));
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_modes();
    t_counts();
    t_clock();
    t_back(0, 32);
    t_back(21, 34);
    stop_test();
  end
endmodule
